// *** hw/i2csd_regs.vh ***
// Summary of operation
// - The bus-busy status flag (bit 3) is set by any START seen on the lines and cleared by any STOP.
// - As master, losing arbitration to another master sets the arbitration-lost flag (bit 2).
// - After a transmitted byte the not-acknowledge flag takes the SDA level seen in the ack slot.
// - A not-acknowledged byte in master transmit mode never causes a STOP on its own.
// - The 8-bit data shift register holds the byte to send or the byte just received.
// - Bytes are shifted out and in most significant bit first, then through the ack slot.
// - At the end of each byte the interrupt flag is set and SCL is held low.
// - In transmit mode any write of the data shift register ends the SCL-low wait.
// - In receive mode a read of the data shift register ends the SCL-low wait.
// - The data shift register sits at special-function address DE hex and resets to zero.
`ifndef I2CSD_REGS_VH
`define I2CSD_REGS_VH

// Special-function addresses
`define I2CSD_DATA_ADDR 8'hDE
`define I2CSD_STATUS_ADDR 8'hDC

// Reset values
`define I2CSD_DATA_RST 8'h00
`define I2CSD_STATUS_RST 8'h00

// Status bit positions
`define I2CSD_ST_DONE 5
`define I2CSD_ST_TX 4
`define I2CSD_ST_BUSY 3
`define I2CSD_ST_LOST 2
`define I2CSD_ST_NACK 1
`define I2CSD_ST_SLAVE 0

// Timing: least SCL half period in ns, clock period in ns, cycles rounded up
`define I2CSD_CLK_NS 40
`define I2CSD_HALF_NS 600
`define I2CSD_HALF_CYC ((`I2CSD_HALF_NS + `I2CSD_CLK_NS - 1) / `I2CSD_CLK_NS)

`endif

// *** hw/i2csd_sync.v ***
`timescale 1ns/1ns
// Three-stage pin synchroniser; the output moves only when stages two and three agree
module i2csd_sync
(
   input wire clock, // System clock
   input wire nrst, // Synchronous reset, active low
   input wire [1:0] pin_in, // Raw pins {scl, sda}
   output reg [1:0] level // Filtered levels {scl, sda}
);
   reg [1:0] stage1;
   reg [1:0] stage2;
   reg [1:0] stage3;

   // Idle bus is high, so every stage resets high
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         stage1 <= 2'h3;
         stage2 <= 2'h3;
         stage3 <= 2'h3;
         level <= 2'h3;
      end
      else
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3)
         begin
            level <= stage3;
         end
      end
   end
endmodule

// *** hw/i2csd_top.v ***
`timescale 1ns/1ns
`include "i2csd_regs.vh"
// Byte engine of the I2C controller: status flags, data shift register and bus wait
module i2csd_top
(
   input wire clock, // 25 MHz system clock
   input wire nrst, // Synchronous reset, active low
   input wire [7:0] sfr_addr, // Special-function address
   input wire sfr_wr, // Write strobe, one cycle
   input wire sfr_rd, // Read strobe, one cycle
   input wire [7:0] sfr_wdata, // Write data
   output reg [7:0] sfr_rdata, // Read data, valid the cycle after sfr_rd
   input wire master_start, // Pulse: begin a master transfer with START
   input wire stop_request_bit, // Level: master asks for a STOP during the wait
   input wire tx_mode, // Level: 1 transmit, 0 receive
   input wire ack_enable, // Level: drive ACK when receiving
   input wire scl_i, // SCL pin level
   output reg scl_o, // SCL output value, always low
   output reg scl_oe, // SCL pulled low while high
   input wire sda_i, // SDA pin level
   output reg sda_o, // SDA output value, always low
   output reg sda_oe // SDA pulled low while high
);
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_MSTART = 3'h1;
   localparam [2:0] S_XFER = 3'h2;
   localparam [2:0] S_HOLD = 3'h3;
   localparam [2:0] S_MSTOP = 3'h4;
   localparam integer HALF_INT = `I2CSD_HALF_CYC - 1;
   localparam [4:0] HALF_LAST = HALF_INT[4:0];

   reg [2:0] state;
   reg [4:0] tmr;
   reg [3:0] bit_cnt;
   reg [7:0] i2c_byte_shift;
   reg bus_in_use_flag, arbitration_lost_flag, nack_response_flag, slave_role_flag;
   reg byte_done_flag, master_act, scl_p, sda_p;
   wire [1:0] lvl;
   wire scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det;
   wire data_wr, data_rd, stat_wr, half_done;

   // Address match, used for both strobes
   function sel;
      input [7:0] addr;
      input [7:0] want;
      begin
         sel = (addr == want);
      end
   endfunction
   i2csd_sync u_sync
   (
      .clock(clock),
      .nrst(nrst),
      .pin_in({scl_i, sda_i}),
      .level(lvl)
   );
   // Bus events from the filtered levels
   assign scl_f = lvl[1];
   assign sda_f = lvl[0];
   assign scl_rise = scl_f & ~scl_p;
   assign scl_fall = ~scl_f & scl_p;
   assign start_det = scl_f & scl_p & sda_p & ~sda_f;
   assign stop_det = scl_f & scl_p & ~sda_p & sda_f;
   assign data_wr = sfr_wr & sel(sfr_addr, `I2CSD_DATA_ADDR);
   assign data_rd = sfr_rd & sel(sfr_addr, `I2CSD_DATA_ADDR);
   assign stat_wr = sfr_wr & sel(sfr_addr, `I2CSD_STATUS_ADDR);
   assign half_done = (tmr == HALF_LAST);
   // Edge history
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end
      else
      begin
         scl_p <= scl_f;
         sda_p <= sda_f;
      end
   end
   // Bus busy follows START and STOP from any master
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         bus_in_use_flag <= 1'b0;
      end
      else if (start_det)
      begin
         bus_in_use_flag <= 1'b1;
      end
      else if (stop_det)
      begin
         bus_in_use_flag <= 1'b0;
      end
   end
   // Registered read data; unmapped addresses read zero
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         sfr_rdata <= 8'h00;
      end
      else if (sfr_rd)
      begin
         if (sel(sfr_addr, `I2CSD_DATA_ADDR))
         begin
            sfr_rdata <= i2c_byte_shift;
         end
         else if (sel(sfr_addr, `I2CSD_STATUS_ADDR))
         begin
            sfr_rdata <= {2'h0, byte_done_flag, tx_mode, bus_in_use_flag,
               arbitration_lost_flag, nack_response_flag, slave_role_flag};
         end
         else
         begin
            sfr_rdata <= 8'h00;
         end
      end
   end

   // Main byte engine; a STOP seen on the bus always returns to idle
   always @(posedge clock)
   begin
      if (!nrst)
      begin
         state <= S_IDLE;
         tmr <= 5'h00;
         bit_cnt <= 4'h0;
         i2c_byte_shift <= `I2CSD_DATA_RST;
         arbitration_lost_flag <= 1'b0;
         nack_response_flag <= 1'b0;
         slave_role_flag <= 1'b0;
         byte_done_flag <= 1'b0;
         master_act <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end
      else
      begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         // Only the interrupt flag is writable; clear loses to a same-cycle set
         if (stat_wr && !sfr_wdata[`I2CSD_ST_DONE])
         begin
            byte_done_flag <= 1'b0;
         end
         // Firmware may load the byte only while nothing is shifting
         if (data_wr && state != S_XFER)
         begin
            i2c_byte_shift <= sfr_wdata;
         end
         if (stop_det)
         begin
            state <= S_IDLE;
            master_act <= 1'b0;
            slave_role_flag <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
         end
         else
         begin
            case (state)
               S_IDLE:
               begin
                  if (master_start && !bus_in_use_flag)
                  begin
                     state <= S_MSTART;
                     master_act <= 1'b1;
                     arbitration_lost_flag <= 1'b0;
                     sda_oe <= 1'b1;
                     tmr <= 5'h00;
                  end
                  else if (start_det)
                  begin
                     // Another master addressed the bus: follow it as slave
                     state <= S_XFER;
                     slave_role_flag <= 1'b1;
                     bit_cnt <= 4'h0;
                  end
               end
               S_MSTART:
               begin
                  tmr <= tmr + 5'h01;
                  if (half_done)
                  begin
                     state <= S_XFER;
                     scl_oe <= 1'b1;
                     tmr <= 5'h00;
                     bit_cnt <= 4'h0;
                     sda_oe <= tx_mode & ~i2c_byte_shift[7];
                  end
               end
               S_XFER:
               begin
                  // Master clock: low half, then high half after any stretching
                  if (master_act)
                  begin
                     if (scl_oe || scl_f)
                     begin
                        tmr <= half_done ? 5'h00 : tmr + 5'h01;
                     end
                     if (half_done && scl_oe)
                     begin
                        scl_oe <= 1'b0;
                     end
                     else if (half_done && scl_f)
                     begin
                        scl_oe <= 1'b1;
                     end
                  end
                  if (scl_rise && bit_cnt < 4'h8)
                  begin
                     // Readback doubles as the arbitration check
                     i2c_byte_shift <= {i2c_byte_shift[6:0], sda_f};
                     bit_cnt <= bit_cnt + 4'h1;
                     if (master_act && tx_mode && !sda_oe && !sda_f)
                     begin
                        arbitration_lost_flag <= 1'b1;
                        byte_done_flag <= 1'b1;
                        master_act <= 1'b0;
                        scl_oe <= 1'b0;
                        state <= S_IDLE;
                     end
                  end
                  else if (scl_rise)
                  begin
                     if (tx_mode)
                     begin
                        nack_response_flag <= sda_f;
                     end
                     bit_cnt <= 4'h9;
                  end
                  else if (scl_fall && bit_cnt == 4'h9)
                  begin
                     // Byte over: flag it and hold SCL low; no automatic STOP
                     byte_done_flag <= 1'b1;
                     scl_oe <= 1'b1;
                     sda_oe <= 1'b0;
                     state <= S_HOLD;
                     bit_cnt <= 4'h0;
                  end
                  else if (scl_fall && bit_cnt == 4'h8)
                  begin
                     sda_oe <= ~tx_mode & ack_enable;
                  end
                  else if (scl_fall)
                  begin
                     sda_oe <= tx_mode & ~i2c_byte_shift[7];
                  end
               end
               S_HOLD:
               begin
                  tmr <= 5'h00;
                  if (master_act && stop_request_bit)
                  begin
                     state <= S_MSTOP;
                     sda_oe <= 1'b1;
                  end
                  else if ((tx_mode && data_wr) || (!tx_mode && data_rd))
                  begin
                     state <= S_XFER;
                     scl_oe <= master_act;
                     sda_oe <= tx_mode & data_wr & ~sfr_wdata[7];
                  end
               end
               S_MSTOP:
               begin
                  // Low half with SDA low, release SCL, then release SDA
                  if (scl_oe || scl_f)
                  begin
                     tmr <= tmr + 5'h01;
                  end
                  if (half_done && scl_oe)
                  begin
                     scl_oe <= 1'b0;
                     tmr <= 5'h00;
                  end
                  else if (half_done && scl_f)
                  begin
                     sda_oe <= 1'b0;
                     master_act <= 1'b0;
                     state <= S_IDLE;
                  end
               end
               default:
               begin
                  state <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// *** verification/i2csd_properties.sv ***
`timescale 1ns/1ns
// Pin-level checks; low_cnt tells a bus wait apart from an ordinary low half
module i2csd_props
(
   input wire clock, // Clock
   input wire nrst, // Reset, active low
   input wire [7:0] sfr_addr, // Address
   input wire sfr_wr, // Write strobe
   input wire sfr_rd, // Read strobe
   input wire [7:0] sfr_wdata, // Write data
   input wire [7:0] sfr_rdata, // Read data
   input wire master_start, // Start pulse
   input wire stop_request_bit, // Stop request
   input wire tx_mode, // Transmit mode
   input wire ack_enable, // Ack enable
   input wire scl_i, // SCL level
   input wire scl_o, // SCL value
   input wire scl_oe, // SCL pull
   input wire sda_i, // SDA level
   input wire sda_o, // SDA value
   input wire sda_oe // SDA pull
);
   reg [5:0] low_cnt;
   reg freed;
   wire hit = sfr_addr == 8'hDE;
   wire in_wait = low_cnt > 6'd20 && !freed;
   // A half bit lasts 15 cycles, so a longer low is the byte wait
   always @(posedge clock)
      if (!nrst || !scl_oe)
         low_cnt <= 6'd0;
      else if (low_cnt != 6'h3F)
         low_cnt <= low_cnt + 6'd1;
   // In master mode SCL stays low one more half after a release, which is no longer the wait
   always @(posedge clock)
      if (!nrst || !scl_oe)
         freed <= 1'b0;
      else if (low_cnt > 6'd20 && (stop_request_bit || hit && (tx_mode ? sfr_wr : sfr_rd)))
         freed <= 1'b1;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!nrst);
   // Line values, read data, and relations between requests and line activity
   a_open_drain: assert property (!scl_o && !sda_o)
      else $error("line value not low");
   a_rdata_stands: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (sfr_rd && !hit && sfr_addr != 8'hDC |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_wait_persists: assert property (in_wait && !sfr_wr && !sfr_rd && !stop_request_bit |=> scl_oe)
      else $error("wait ended unasked");
   a_tx_msb_out: assert property (in_wait && tx_mode && sfr_wr && hit && !stop_request_bit
      |=> scl_oe && sda_oe == !$past(sfr_wdata[7]))
      else $error("first bit not the top bit");
   a_tx_release: assert property (in_wait && tx_mode && sfr_wr && hit && !stop_request_bit
      |-> ##[1:20] !scl_oe)
      else $error("write did not end the wait");
   a_rx_release: assert property (in_wait && !tx_mode && sfr_rd && hit && !stop_request_bit
      |-> ##[1:20] !scl_oe)
      else $error("read did not end the wait");
   a_stop_asked: assert property ($fell(sda_oe) && scl_i && !scl_oe |-> stop_request_bit)
      else $error("stop without request");
   c_tx_wait: cover property (in_wait && tx_mode);
   c_rx_release: cover property (in_wait && !tx_mode && sfr_rd && hit);
   c_stop: cover property (stop_request_bit && $rose(sda_i));
endmodule
bind i2csd_top i2csd_props chk_u (.clock(clock), .nrst(nrst), .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .master_start(master_start), .stop_request_bit(stop_request_bit), .tx_mode(tx_mode),
   .ack_enable(ack_enable), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

// *** verification/i2csd_peer.sv ***
`timescale 1ns/1ns
// Far-side slave: acknowledges or refuses bytes, and can send one byte back
module i2csd_peer
(
   input wire scl, // SCL wire
   input wire sda, // SDA wire
   input wire ack_on, // Acknowledge bytes
   input wire send_on, // Act as transmitter
   input wire [7:0] send_byte, // Byte to send
   output reg sda_pull = 1'b0, // Pulls SDA low while high
   output reg [7:0] got_byte = 8'h00 // Last byte seen
);
   integer count = 0;
   // A START restarts the bit count
   always @(negedge sda)
      if (scl)
         count = 0;
   // Bits are taken on the rising edge, top bit first; the ack bit is not kept
   always @(posedge scl)
   begin
      if (count < 8)
         got_byte = {got_byte[6:0], sda};
      count = (count == 8) ? 0 : count + 1;
   end
   // SDA changes only while SCL is low, so the master never sees a false START
   always @(negedge scl or posedge send_on)
      if (!scl)
         sda_pull = (count == 8) ? ack_on && !send_on : send_on && !send_byte[7 - count];
endmodule

// *** verification/tb_i2csd_top.sv ***
`timescale 1ns/1ns
`include "i2csd_regs.vh"
module tb_i2csd_top;
   localparam [7:0] da = `I2CSD_DATA_ADDR;
   localparam [7:0] st = `I2CSD_STATUS_ADDR;
   reg clock = 1'b0;
   reg nrst = 1'b0;
   reg [7:0] sfr_addr = 8'h00;
   reg [7:0] sfr_wdata = 8'h00;
   reg sfr_wr = 1'b0, sfr_rd = 1'b0, master_start = 1'b0, stop_request_bit = 1'b0;
   reg tx_mode = 1'b0, ack_on = 1'b1, send_on = 1'b0, tb_scl_pull = 1'b0, tb_sda_pull = 1'b0;
   reg [7:0] v;
   wire [7:0] sfr_rdata, got_byte;
   wire scl_o, scl_oe, sda_o, sda_oe, peer_pull;
   integer errors = 0, compares = 0;
   // Open-drain wires with pull-ups; any party pulling wins
   wire scl = !(scl_oe || tb_scl_pull);
   wire sda = !(sda_oe || tb_sda_pull || peer_pull);
   initial forever #20 clock = !clock;
   i2csd_top dut (.clock(clock), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .master_start(master_start), .stop_request_bit(stop_request_bit), .tx_mode(tx_mode),
      .ack_enable(1'b1), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe));
   i2csd_peer peer (.scl(scl), .sda(sda), .ack_on(ack_on), .send_on(send_on),
      .send_byte(8'hC3), .sda_pull(peer_pull), .got_byte(got_byte));
   // Inputs always move 1 ns after the rising edge
   task cyc(input integer n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task conclude;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task cmp(input [7:0] got, input [7:0] want);
      compares = compares + 1;
      if (got !== want)
      begin
         errors = errors + 1;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task tmo;
      errors = errors + 1;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      conclude;
   endtask
   // A spare cycle after each strobe keeps it from being driven twice at once
   task wr(input [7:0] a, input [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      cyc(1);
      sfr_wr = 1'b0;
      cyc(1);
   endtask
   task rd(input [7:0] a);
      sfr_addr = a;
      sfr_rd = 1'b1;
      cyc(1);
      sfr_rd = 0;
      v = sfr_rdata;
      cyc(1);
   endtask
   task chk(input [7:0] a, input [7:0] want);
      rd(a);
      cmp(v, want);
   endtask
   // Polls one status bit; status reads never release the bus wait
   task wait_st(input integer n, input val);
      integer k;
      rd(st);
      for (k = 0; k < 3000 && v[n] !== val; k = k + 1)
         rd(st);
      if (v[n] !== val)
         tmo;
   endtask
   task go;
      master_start = 1'b1;
      cyc(1);
      master_start = 1'b0;
   endtask
   task t_regs;
      chk(da, 8'h00);
      chk(st, 8'h00);
      wr(st, 8'hFF);
      chk(st, 8'h00);
      chk(8'hDD, 8'h00);
      wr(da, 8'h5A);
      chk(da, 8'h5A);
   endtask
   // Another master: START then STOP, four cycles from SDA to SCL and ten with SCL low, under the 15-cycle half of the link rate
   task t_ext;
      tb_sda_pull = 1'b1;
      cyc(4);
      tb_scl_pull = 1'b1;
      cyc(8);
      chk(st, 8'h09);
      tb_scl_pull = 1'b0;
      cyc(4);
      tb_sda_pull = 1'b0;
      cyc(8);
      chk(st, 8'h00);
   endtask
   task t_tx;
      tx_mode = 1'b1;
      wr(da, 8'hA5);
      go;
      wait_st(5, 1'b1);
      cmp(got_byte, 8'hA5);
      chk(st, 8'h38);
      cyc(60);
      cmp({7'h00, scl}, 8'h00);
      wr(st, 8'h00);
      chk(st, 8'h18);
      ack_on = 1'b0;
      wr(da, 8'h3C);
      wait_st(5, 1'b1);
      cmp(got_byte, 8'h3C);
      cyc(200);
      chk(st, 8'h3A);
   endtask
   task t_rx;
      tx_mode = 1'b0;
      send_on = 1'b1;
      wr(st, 8'h00);
      rd(da);
      wait_st(5, 1'b1);
      stop_request_bit = 1'b1;
      wait_st(3, 1'b0);
      stop_request_bit = 1'b0;
      send_on = 1'b0;
      cmp(v & 8'hFD, 8'h20);
      chk(da, 8'hC3);
   endtask
   // A second master holds SDA low while the block sends a one
   task t_arb;
      integer k;
      wr(st, 8'h00);
      wr(da, 8'hFF);
      tx_mode = 1'b1;
      go;
      for (k = 0; k < 40 && sda_oe !== 1'b1; k = k + 1)
         cyc(1);
      if (sda_oe !== 1'b1)
         tmo;
      cyc(2);
      tb_sda_pull = 1'b1;
      wait_st(2, 1'b1);
      rd(st);
      cmp(v & 8'hFD, 8'h3C);
      tb_sda_pull = 1'b0;
      cyc(10);
      rd(st);
      cmp(v & 8'h08, 8'h00);
   endtask
   initial
   begin
      cyc(8);
      nrst = 1'b1;
      t_regs;
      t_ext;
      t_tx;
      t_rx;
      t_arb;
      conclude;
   end
endmodule
